// File: design/gpr_ctrl_top.sv
// Power, reset, clock-select and FIFO control register block
//
// Notes on behaviour
// - Temperature reset bit pulses temperature path only.
// - FIFO enable bit gates host FIFO access.
// - Two-wire disable ignores two-wire host accesses.
// - FIFO reset clears FIFO, self-clears after one.
// - Full clear resets both paths, clears outputs.
// - Device reset restores defaults, reads zero after.
// - Sleep bit, default one, selects sleep.
// - Gyro standby keeps drive, stops sense paths.
// - Thermal off bit disables temperature sensor.
// - Clock field selects oscillator, PLL or stop.
// - Axis standby bits turn X, Y, Z off.
// - Byte count split over upper, lower registers.
// - Upper count read captures both count bytes.
// - Data port read pops, write pushes.
// - Empty FIFO reads as all ones.
// - Overflow drops oldest unless stop-on-full.
// - Overflow raises the overrun flag.
`timescale 1ns/1ps
`include "gpr_regs.svh"
module gpr_ctrl_top #(
  parameter int FIFO_DEPTH = 512,
  parameter int CNT_W = 13
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire gpr_pkg::gpr_reg_req_t reg_req,
  output logic [7:0] rd_data,
  output logic rd_valid,
  input wire logic sample_valid,
  output logic sample_ready,
  input wire logic [7:0] sample_data,
  input wire logic stop_on_full,
  input wire logic pll_ready,
  output gpr_pkg::gpr_power_t power,
  output logic temp_path_reset,
  output logic gyro_path_reset,
  output logic sensor_regs_clear,
  output logic fifo_overrun_flag
);
  import gpr_pkg::*;

  localparam int CW = $clog2(FIFO_DEPTH) + 1;
  localparam int RW = `GPR_RST_CNT_W;

  generate
    if (CNT_W < CW || CNT_W < 9 || CNT_W > 16) begin : g_chk
      $error("gpr_ctrl_top: CNT_W must hold FIFO_DEPTH, 9 to 16 bits");
    end
  endgenerate

  logic [7:0] ufc_q;
  logic [7:0] pcc_q;
  logic [7:0] axs_q;
  logic [RW-1:0] fifo_rst_cnt_q;
  logic [RW-1:0] dev_rst_cnt_q;
  gpr_rst_state_t rst_state_q;
  logic [CNT_W-1:0] cnt_snap_q;
  logic [7:0] rd_data_q;
  logic rd_valid_q;
  gpr_power_t power_q;
  logic temp_rst_q;
  logic gyro_rst_q;
  logic out_clear_q;
  logic overrun_q;

  logic acc_ok;
  logic wr_hit;
  logic rd_hit;
  logic dev_busy;
  logic fifo_en;
  logic fifo_clear;
  logic host_pop;
  logic host_push;
  logic host_push_eff;
  logic buf_valid;
  logic buf_ready;
  logic [7:0] buf_data;
  logic buf_take;
  logic drop_oldest;
  logic fifo_push;
  logic fifo_pop;
  logic [7:0] fifo_push_data;
  logic [7:0] fifo_head;
  logic [CW-1:0] fifo_level;
  logic fifo_full;
  logic fifo_empty;
  logic [CNT_W-1:0] live_cnt;
  gpr_clk_src_t clk_src;

  // Decode the 3-bit clock field into a source choice
  function automatic gpr_clk_src_t clk_decode(input logic [2:0] code,
                                              input logic pll_ok);
    gpr_clk_src_t src;
    src = CLK_OSC;
    if (code == 3'h7) begin
      src = CLK_STOP;
    end else if (code != 3'h0 && code != 3'h6 && pll_ok) begin
      src = CLK_PLL;
    end
    return src;
  endfunction : clk_decode

  // Accesses arriving over two-wire are dropped while it is disabled
  assign acc_ok = !(reg_req.via_two_wire &&
                    ufc_q[`GPR_UFC_TWO_WIRE_DIS]);
  assign dev_busy = (rst_state_q == RST_BUSY);
  assign wr_hit = reg_req.wr && acc_ok && !dev_busy;
  assign rd_hit = reg_req.rd && !reg_req.wr && acc_ok;
  assign fifo_en = ufc_q[`GPR_UFC_FIFO_EN];
  assign fifo_clear = (fifo_rst_cnt_q != '0) || dev_busy;

  assign host_pop = rd_hit && fifo_en && !fifo_empty && !fifo_clear &&
                    (reg_req.addr == `GPR_OFS_FIFO_BYTE_PORT);
  assign host_push = wr_hit && fifo_en && !fifo_clear &&
                     (reg_req.addr == `GPR_OFS_FIFO_BYTE_PORT);
  // Under stop-on-full a host byte into a full FIFO is lost
  assign host_push_eff = host_push && !(fifo_full && stop_on_full);

  // Host writes own the single write port; the buffer waits a cycle
  assign buf_ready = !host_push && !fifo_clear &&
                     (!fifo_full || !stop_on_full);
  assign buf_take = buf_valid && buf_ready;
  assign fifo_push = host_push_eff || buf_take;
  assign fifo_push_data = host_push ? reg_req.wdata : buf_data;
  assign drop_oldest = fifo_push && fifo_full && !host_pop;
  assign fifo_pop = host_pop || drop_oldest;
  assign live_cnt = CNT_W'(fifo_level);

  gpr_skid_buf #(
    .WIDTH(8)
  ) u_sample_buf (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .in_valid(sample_valid),
    .in_ready(sample_ready),
    .in_data(sample_data),
    .out_valid(buf_valid),
    .out_ready(buf_ready),
    .out_data(buf_data)
  );

  gpr_fifo_mem #(
    .DEPTH(FIFO_DEPTH),
    .WIDTH(8)
  ) u_fifo (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .clear(fifo_clear),
    .push(fifo_push),
    .push_data(fifo_push_data),
    .pop(fifo_pop),
    .pop_data(fifo_head),
    .level(fifo_level),
    .full(fifo_full),
    .empty(fifo_empty)
  );

  // Device reset sequencer: holds registers at defaults while busy
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_state_q <= RST_IDLE;
      dev_rst_cnt_q <= '0;
    end else begin
      case (rst_state_q)
        RST_IDLE: begin
          if (wr_hit && reg_req.addr == `GPR_OFS_POWER_CLOCK &&
              reg_req.wdata[`GPR_PCC_DEV_RST]) begin
            rst_state_q <= RST_BUSY;
            dev_rst_cnt_q <= RW'(`GPR_DEV_RST_CYC);
          end
        end
        RST_BUSY: begin
          dev_rst_cnt_q <= dev_rst_cnt_q - RW'(1);
          if (dev_rst_cnt_q == RW'(1)) begin
            rst_state_q <= RST_IDLE;
          end
        end
        default: begin
          rst_state_q <= RST_IDLE;
        end
      endcase
    end
  end

  // Control registers; reserved bits are never stored
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ufc_q <= `GPR_UFC_RESET;
      pcc_q <= `GPR_PCC_RESET;
      axs_q <= `GPR_AXS_RESET;
    end else if (dev_busy) begin
      ufc_q <= `GPR_UFC_RESET;
      pcc_q <= `GPR_PCC_RESET;
      axs_q <= `GPR_AXS_RESET;
    end else if (wr_hit) begin
      if (reg_req.addr == `GPR_OFS_IF_FIFO_CTRL) begin
        ufc_q[`GPR_UFC_FIFO_EN] <= reg_req.wdata[`GPR_UFC_FIFO_EN];
        ufc_q[`GPR_UFC_TWO_WIRE_DIS] <=
          reg_req.wdata[`GPR_UFC_TWO_WIRE_DIS];
      end else if (reg_req.addr == `GPR_OFS_POWER_CLOCK) begin
        pcc_q[`GPR_PCC_SLEEP] <= reg_req.wdata[`GPR_PCC_SLEEP];
        pcc_q[`GPR_PCC_GYRO_STBY] <= reg_req.wdata[`GPR_PCC_GYRO_STBY];
        pcc_q[`GPR_PCC_THERM_OFF] <= reg_req.wdata[`GPR_PCC_THERM_OFF];
        pcc_q[`GPR_PCC_CLK_HI:0] <= reg_req.wdata[`GPR_PCC_CLK_HI:0];
      end else if (reg_req.addr == `GPR_OFS_AXIS_STANDBY) begin
        axs_q[`GPR_AXS_X_OFF:0] <= reg_req.wdata[`GPR_AXS_X_OFF:0];
      end
    end
  end

  // FIFO reset bit stays set for one internal oscillator period
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fifo_rst_cnt_q <= '0;
    end else if (wr_hit && reg_req.addr == `GPR_OFS_IF_FIFO_CTRL &&
                 reg_req.wdata[`GPR_UFC_FIFO_RST]) begin
      fifo_rst_cnt_q <= RW'(`GPR_FIFO_RST_CYC);
    end else if (fifo_rst_cnt_q != '0) begin
      fifo_rst_cnt_q <= fifo_rst_cnt_q - RW'(1);
    end
  end

  // Signal-path reset pulses
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      temp_rst_q <= 1'b0;
      gyro_rst_q <= 1'b0;
      out_clear_q <= 1'b0;
    end else begin
      temp_rst_q <= wr_hit &&
        ((reg_req.addr == `GPR_OFS_SENSOR_PATH_RESET &&
          reg_req.wdata[`GPR_SPR_TEMP_RST]) ||
         (reg_req.addr == `GPR_OFS_IF_FIFO_CTRL &&
          reg_req.wdata[`GPR_UFC_FULL_CLEAR]));
      gyro_rst_q <= wr_hit && reg_req.addr == `GPR_OFS_IF_FIFO_CTRL &&
        reg_req.wdata[`GPR_UFC_FULL_CLEAR];
      out_clear_q <= wr_hit && reg_req.addr == `GPR_OFS_IF_FIFO_CTRL &&
        reg_req.wdata[`GPR_UFC_FULL_CLEAR];
    end
  end

  // Overrun: oldest byte dropped, host byte refused or sample stalled by a full FIFO, except while clearing
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      overrun_q <= 1'b0;
    end else begin
      overrun_q <= !fifo_clear && (drop_oldest ||
        (host_push && !host_push_eff) ||
        (sample_valid && !sample_ready && fifo_full));
    end
  end

  // Count snapshot taken when the upper count byte is read
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_snap_q <= '0;
    end else if (dev_busy) begin
      cnt_snap_q <= '0;
    end else if (rd_hit && reg_req.addr == `GPR_OFS_FIFO_LEVEL_UPPER) begin
      cnt_snap_q <= live_cnt;
    end
  end

  // Read path, answered one cycle after the request
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_q <= 8'h00;
      rd_valid_q <= 1'b0;
    end else begin
      rd_valid_q <= rd_hit;
      if (rd_hit) begin
        if (reg_req.addr == `GPR_OFS_SENSOR_PATH_RESET) begin
          rd_data_q <= 8'h00;
        end else if (reg_req.addr == `GPR_OFS_IF_FIFO_CTRL) begin
          rd_data_q <= {1'b0, ufc_q[`GPR_UFC_FIFO_EN], 1'b0,
                        ufc_q[`GPR_UFC_TWO_WIRE_DIS], 1'b0,
                        fifo_rst_cnt_q != '0, 2'b00};
        end else if (reg_req.addr == `GPR_OFS_POWER_CLOCK) begin
          rd_data_q <= {dev_busy, pcc_q[6], 1'b0, pcc_q[4:0]};
        end else if (reg_req.addr == `GPR_OFS_AXIS_STANDBY) begin
          rd_data_q <= {5'b00000, axs_q[2:0]};
        end else if (reg_req.addr == `GPR_OFS_FIFO_LEVEL_UPPER) begin
          rd_data_q <= 8'({live_cnt[CNT_W-1:8]});
        end else if (reg_req.addr == `GPR_OFS_FIFO_LEVEL_LOWER) begin
          rd_data_q <= cnt_snap_q[7:0];
        end else if (reg_req.addr == `GPR_OFS_FIFO_BYTE_PORT) begin
          rd_data_q <= host_pop ? fifo_head : `GPR_FIFO_EMPTY_BYTE;
        end else begin
          rd_data_q <= `GPR_UNMAPPED_BYTE;
        end
      end
    end
  end

  assign clk_src = clk_decode(pcc_q[`GPR_PCC_CLK_HI:0], pll_ready);

  // Power and clock controls to the analogue and timing blocks
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      power_q <= '0;
      power_q.sleep <= 1'b1;
    end else begin
      power_q.sleep <= pcc_q[`GPR_PCC_SLEEP];
      power_q.gyro_drive_on <= !pcc_q[`GPR_PCC_SLEEP];
      power_q.sense_path_on <= !pcc_q[`GPR_PCC_SLEEP] &&
                               !pcc_q[`GPR_PCC_GYRO_STBY];
      power_q.thermal_sensor_off <= pcc_q[`GPR_PCC_THERM_OFF];
      power_q.x_axis_off <= axs_q[`GPR_AXS_X_OFF];
      power_q.y_axis_off <= axs_q[`GPR_AXS_Y_OFF];
      power_q.z_axis_off <= axs_q[`GPR_AXS_Z_OFF];
      power_q.clk_use_pll <= (clk_src == CLK_PLL);
      power_q.clk_stopped <= (clk_src == CLK_STOP);
      power_q.timing_gen_reset <= (clk_src == CLK_STOP);
      power_q.two_wire_port_disable <= ufc_q[`GPR_UFC_TWO_WIRE_DIS];
    end
  end

  assign rd_data = rd_data_q;
  assign rd_valid = rd_valid_q;
  assign power = power_q;
  assign temp_path_reset = temp_rst_q;
  assign gyro_path_reset = gyro_rst_q;
  assign sensor_regs_clear = out_clear_q;
  assign fifo_overrun_flag = overrun_q;

endmodule : gpr_ctrl_top

// File: inc/gpr_regs.svh
// Register offsets, field positions, reset values and timing counts
`ifndef GPR_REGS_SVH
`define GPR_REGS_SVH

`define GPR_ADDR_W 7
`define GPR_OFS_SENSOR_PATH_RESET 7'h68
`define GPR_OFS_IF_FIFO_CTRL 7'h6A
`define GPR_OFS_POWER_CLOCK 7'h6B
`define GPR_OFS_AXIS_STANDBY 7'h6C
`define GPR_OFS_FIFO_LEVEL_UPPER 7'h72
`define GPR_OFS_FIFO_LEVEL_LOWER 7'h73
`define GPR_OFS_FIFO_BYTE_PORT 7'h74

`define GPR_SPR_TEMP_RST 0
`define GPR_UFC_FIFO_EN 6
`define GPR_UFC_TWO_WIRE_DIS 4
`define GPR_UFC_FIFO_RST 2
`define GPR_UFC_FULL_CLEAR 0
`define GPR_PCC_DEV_RST 7
`define GPR_PCC_SLEEP 6
`define GPR_PCC_GYRO_STBY 4
`define GPR_PCC_THERM_OFF 3
`define GPR_PCC_CLK_HI 2
`define GPR_AXS_X_OFF 2
`define GPR_AXS_Y_OFF 1
`define GPR_AXS_Z_OFF 0

`define GPR_UFC_RESET 8'h00
`define GPR_PCC_RESET 8'h40
`define GPR_AXS_RESET 8'h00
`define GPR_FIFO_EMPTY_BYTE 8'hFF
`define GPR_UNMAPPED_BYTE 8'h00

`define GPR_CLK_MHZ 100
`define GPR_OSC_PERIOD_NS 50
`define GPR_FIFO_RST_CYC ((`GPR_OSC_PERIOD_NS * `GPR_CLK_MHZ + 999) / 1000)
`define GPR_DEV_RST_CYC 4
`define GPR_RST_CNT_W 4

`endif

// File: inc/gpr_pkg.sv
// Types shared by the control register block
package gpr_pkg;

  typedef enum logic [1:0] {
    CLK_OSC,
    CLK_PLL,
    CLK_STOP
  } gpr_clk_src_t;

  typedef enum logic {
    RST_IDLE,
    RST_BUSY
  } gpr_rst_state_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic via_two_wire;
    logic [6:0] addr;
    logic [7:0] wdata;
  } gpr_reg_req_t;

  typedef struct packed {
    logic sleep;
    logic gyro_drive_on;
    logic sense_path_on;
    logic thermal_sensor_off;
    logic x_axis_off;
    logic y_axis_off;
    logic z_axis_off;
    logic clk_use_pll;
    logic clk_stopped;
    logic timing_gen_reset;
    logic two_wire_port_disable;
  } gpr_power_t;

endpackage : gpr_pkg

// File: design/gpr_skid_buf.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module gpr_skid_buf #(
  parameter int WIDTH = 8
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  import gpr_pkg::*;

  logic [WIDTH-1:0] slot_q [2];
  logic wptr_q;
  logic rptr_q;
  logic [1:0] cnt_q;
  logic take;
  logic give;

  generate
    if (WIDTH < 1) begin : g_chk
      $error("gpr_skid_buf: WIDTH must be at least 1");
    end
  endgenerate

  assign in_ready = (cnt_q != 2'd2);
  assign out_valid = (cnt_q != 2'd0);
  assign out_data = slot_q[rptr_q];
  assign take = in_valid && in_ready;
  assign give = out_valid && out_ready;

  always_ff @(posedge core_clk) begin
    if (take) begin
      slot_q[wptr_q] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wptr_q <= 1'b0;
      rptr_q <= 1'b0;
      cnt_q <= 2'd0;
    end else begin
      if (take) begin
        wptr_q <= ~wptr_q;
      end
      if (give) begin
        rptr_q <= ~rptr_q;
      end
      if (take && !give) begin
        cnt_q <= cnt_q + 2'd1;
      end else if (give && !take) begin
        cnt_q <= cnt_q - 2'd1;
      end
    end
  end

endmodule : gpr_skid_buf

// File: design/gpr_fifo_mem.sv
// Byte FIFO storage with pointers, level, clear and simultaneous push/pop
`timescale 1ns/1ps
module gpr_fifo_mem #(
  parameter int DEPTH = 512,
  parameter int WIDTH = 8,
  parameter int CW = $clog2(DEPTH) + 1
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic clear,
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  input wire logic pop,
  output logic [WIDTH-1:0] pop_data,
  output logic [CW-1:0] level,
  output logic full,
  output logic empty
);
  import gpr_pkg::*;

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_q;
  logic [AW-1:0] rptr_q;
  logic [CW-1:0] level_q;
  logic do_push;
  logic do_pop;

  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_chk
      $error("gpr_fifo_mem: DEPTH must be a power of two, 2 or more");
    end
  endgenerate

  assign full = (level_q == CW'(DEPTH));
  assign empty = (level_q == '0);
  assign level = level_q;
  assign pop_data = mem[rptr_q];
  // A push into a full FIFO is only legal together with a pop
  assign do_push = push && (!full || pop);
  assign do_pop = pop && !empty;

  always_ff @(posedge core_clk) begin
    if (do_push && !clear) begin
      mem[wptr_q] <= push_data;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wptr_q <= '0;
      rptr_q <= '0;
      level_q <= '0;
    end else if (clear) begin
      wptr_q <= '0;
      rptr_q <= '0;
      level_q <= '0;
    end else begin
      if (do_push) begin
        wptr_q <= wptr_q + AW'(1);
      end
      if (do_pop) begin
        rptr_q <= rptr_q + AW'(1);
      end
      if (do_push && !do_pop) begin
        level_q <= level_q + CW'(1);
      end else if (do_pop && !do_push) begin
        level_q <= level_q - CW'(1);
      end
    end
  end

endmodule : gpr_fifo_mem

// File: testbench/gpr_ctrl_properties.sv
// Port checker for the control register block
`timescale 1ns/1ps
module gpr_ctrl_checker #(
  parameter int FIFO_DEPTH = 512,
  parameter int CNT_W = 13
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire gpr_pkg::gpr_reg_req_t reg_req,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid,
  input wire logic sample_valid,
  input wire logic sample_ready,
  input wire logic [7:0] sample_data,
  input wire logic stop_on_full,
  input wire logic pll_ready,
  input wire gpr_pkg::gpr_power_t power,
  input wire logic temp_path_reset,
  input wire logic gyro_path_reset,
  input wire logic sensor_regs_clear,
  input wire logic fifo_overrun_flag
);
  import gpr_pkg::*;
  logic [2:0] busy_q;
  logic spi_rd;
  assign spi_rd = reg_req.rd && !reg_req.wr && !reg_req.via_two_wire;
  // Conservative window covering a device reset, when writes are refused
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_q <= 3'h0;
    end else if (reg_req.wr && !reg_req.via_two_wire &&
                 reg_req.addr == 7'h6B && reg_req.wdata[7]) begin
      busy_q <= 3'h6;
    end else if (busy_q != 3'h0) begin
      busy_q <= busy_q - 3'h1;
    end
  end
  function automatic logic [2:0] clk_exp(logic [2:0] c, logic p);
    if (c == 3'h7) return 3'h6;
    if (c >= 3'h1 && c <= 3'h5) return {2'h0, p};
    return 3'h0;
  endfunction : clk_exp
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  sequence s_wr(logic [6:0] a);
    reg_req.wr && !reg_req.via_two_wire && reg_req.addr == a && busy_q == 3'h0;
  endsequence
  sequence s_rd(logic [6:0] a);
    spi_rd && reg_req.addr == a;
  endsequence
  sequence s_fifo_rst;
    s_wr(7'h6A) ##0 reg_req.wdata[2];
  endsequence
  property p_spr_read;
    s_rd(7'h68) |=> rd_valid && rd_data == 8'h00;
  endproperty
  a_spr_read: assert property (p_spr_read) else $error("pulse reg");
  property p_resv;
    spi_rd && reg_req.addr inside {7'h6A, 7'h6B, 7'h6C} |=> rd_valid &&
      (rd_data & ($past(reg_req.addr) == 7'h6A ? 8'hAB :
       $past(reg_req.addr) == 7'h6B ? 8'h20 : 8'hF8)) == 8'h00;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved bit set");
  property p_temp_rst;
    s_wr(7'h68) ##0 reg_req.wdata[0] |=>
      temp_path_reset && !gyro_path_reset && !sensor_regs_clear;
  endproperty
  a_temp_rst: assert property (p_temp_rst) else $error("temp reset");
  property p_full_clear;
    s_wr(7'h6A) ##0 reg_req.wdata[0] |=>
      temp_path_reset && gyro_path_reset && sensor_regs_clear;
  endproperty
  a_full_clear: assert property (p_full_clear) else $error("clear");
  property p_fifo_rst_busy;
    s_fifo_rst ##[1:3] s_rd(7'h6A) |=> rd_valid && rd_data[2];
  endproperty
  a_fifo_rst_busy: assert property (p_fifo_rst_busy) else $error("rst");
  property p_fifo_rst_done;
    s_fifo_rst ##[7:20] s_rd(7'h6A) |=> rd_valid && !rd_data[2];
  endproperty
  a_fifo_rst_done: assert property (p_fifo_rst_done) else $error("rst");
  property p_power;
    s_wr(7'h6B) ##0 !reg_req.wdata[7] |-> ##2
      power.sleep == $past(reg_req.wdata[6], 2) &&
      power.gyro_drive_on == !$past(reg_req.wdata[6], 2) &&
      power.sense_path_on == !($past(reg_req.wdata[6], 2) ||
                               $past(reg_req.wdata[4], 2)) &&
      power.thermal_sensor_off == $past(reg_req.wdata[3], 2);
  endproperty
  a_power: assert property (p_power) else $error("power state");
  property p_clk_src;
    s_wr(7'h6B) ##0 !reg_req.wdata[7] |-> ##2
      {power.clk_stopped, power.timing_gen_reset, power.clk_use_pll} ==
      clk_exp($past(reg_req.wdata[2:0], 2), $past(pll_ready));
  endproperty
  a_clk_src: assert property (p_clk_src) else $error("clock source");
  property p_axis;
    s_wr(7'h6C) |-> ##2 {power.x_axis_off, power.y_axis_off,
      power.z_axis_off} == $past(reg_req.wdata[2:0], 2);
  endproperty
  a_axis: assert property (p_axis) else $error("axis standby");
  property p_two_wire;
    reg_req.rd && !reg_req.wr && reg_req.via_two_wire &&
      power.two_wire_port_disable && $past(power.two_wire_port_disable) &&
      !$past(reg_req.wr) |=> !rd_valid;
  endproperty
  a_two_wire: assert property (p_two_wire) else $error("two-wire");
endmodule : gpr_ctrl_checker

bind gpr_ctrl_top gpr_ctrl_checker #(.FIFO_DEPTH(FIFO_DEPTH), .CNT_W(CNT_W))
  i_gpr_ctrl_checker (.core_clk(core_clk), .arst_n(arst_n),
  .reg_req(reg_req), .rd_data(rd_data), .rd_valid(rd_valid),
  .sample_valid(sample_valid), .sample_ready(sample_ready),
  .sample_data(sample_data), .stop_on_full(stop_on_full),
  .pll_ready(pll_ready), .power(power), .temp_path_reset(temp_path_reset),
  .gyro_path_reset(gyro_path_reset), .sensor_regs_clear(sensor_regs_clear),
  .fifo_overrun_flag(fifo_overrun_flag));

// File: testbench/gpr_host.sv
// Host model issuing register accesses on the falling clock edge
`timescale 1ns/1ps
module gpr_host (
  input wire logic core_clk,
  output gpr_pkg::gpr_reg_req_t reg_req,
  input wire logic [7:0] rd_data,
  input wire logic rd_valid
);
  import gpr_pkg::*;
  initial reg_req = 18'h0;
  // Idle fields are inverted so stale values are never mistaken for requests
  task automatic wr(input logic [6:0] a, input logic [7:0] v,
                    input logic tw);
    @(negedge core_clk);
    reg_req = {1'b1, 1'b0, tw, a, v};
    @(negedge core_clk);
    reg_req = {2'b00, ~reg_req[15:0]};
  endtask : wr
  // No answer in the following cycle gives all unknown
  task automatic rd(input logic [6:0] a, output logic [7:0] v,
                    input logic tw);
    @(negedge core_clk);
    reg_req = {1'b0, 1'b1, tw, a, reg_req[7:0]};
    @(negedge core_clk);
    reg_req = {2'b00, ~reg_req[15:0]};
    v = (rd_valid === 1'b1) ? rd_data : 8'hxx;
  endtask : rd
  task automatic level(output logic [15:0] n);
    logic [7:0] hi;
    logic [7:0] lo;
    rd(7'h72, hi, 1'b0);
    rd(7'h73, lo, 1'b0);
    n = {hi, lo};
  endtask : level
  task automatic start;
    wr(7'h6B, 8'h01, 1'b0);
  endtask : start
endmodule : gpr_host

// File: testbench/gpr_ctrl_top_tb.sv
// Self-checking testbench for the control register block
`timescale 1ns/1ps
module gpr_ctrl_top_tb;
  import gpr_pkg::*;
  localparam int DEPTH = 512;
  logic core_clk, arst_n, rd_valid, sample_valid, sample_ready;
  logic stop_on_full, pll_ready, temp_path_reset, gyro_path_reset;
  logic sensor_regs_clear, fifo_overrun_flag;
  logic [7:0] rd_data, sample_data, d, v, sb;
  logic [15:0] n;
  gpr_reg_req_t reg_req;
  gpr_power_t power;
  int fails, checks_done, ovf, seed;
  logic [7:0] q[$];
  gpr_ctrl_top #(.FIFO_DEPTH(DEPTH), .CNT_W(13)) i_gpr_ctrl_top (
    .core_clk(core_clk), .arst_n(arst_n), .reg_req(reg_req),
    .rd_data(rd_data), .rd_valid(rd_valid), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .sample_data(sample_data),
    .stop_on_full(stop_on_full), .pll_ready(pll_ready), .power(power),
    .temp_path_reset(temp_path_reset), .gyro_path_reset(gyro_path_reset),
    .sensor_regs_clear(sensor_regs_clear),
    .fifo_overrun_flag(fifo_overrun_flag));
  gpr_host i_gpr_host (.core_clk(core_clk), .reg_req(reg_req),
    .rd_data(rd_data), .rd_valid(rd_valid));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always @(negedge core_clk) begin
    if (fifo_overrun_flag === 1'b1) ovf++;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic w(input logic [6:0] a, input logic [7:0] x,
                   input logic tw = 1'b0);
    i_gpr_host.wr(a, x, tw);
  endtask : w
  task automatic rc(input logic [6:0] a, input logic [7:0] e,
                    input logic tw = 1'b0);
    i_gpr_host.rd(a, d, tw);
    chk(d, e);
  endtask : rc
  task automatic send(input logic [7:0] x);
    @(negedge core_clk);
    sample_valid = 1'b1;
    sample_data = x;
    while (sample_ready !== 1'b1) @(negedge core_clk);
    @(posedge core_clk);
  endtask : send
  task automatic drain;
    while (q.size() > 0) rc(7'h74, q.pop_front());
    rc(7'h74, 8'hFF);
  endtask : drain
  task automatic results;
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : results
  initial begin
    #100000;
    fails++;
    results();
  end
  initial begin
    seed = 32'heaf0;
    arst_n = 1'b0;
    sample_valid = 1'b0;
    sample_data = 8'h00;
    stop_on_full = 1'b0;
    pll_ready = 1'b0;
    repeat (12) @(negedge core_clk);
    arst_n = 1'b1;
    rc(7'h68, 8'h00);
    rc(7'h6A, 8'h00);
    rc(7'h6B, 8'h40);
    rc(7'h6C, 8'h00);
    rc(7'h10, 8'h00);
    rc(7'h74, 8'hFF);
    i_gpr_host.start();
    for (int c = 0; c < 8; c++) begin
      pll_ready = 1'($random(seed));
      v = (8'($random(seed)) & 8'h78) | 8'(c);
      w(7'h6B, v);
      rc(7'h6B, v & 8'h5F);
    end
    w(7'h6B, 8'h01);
    v = 8'($random(seed));
    sb = v & 8'h07;
    w(7'h6C, v);
    rc(7'h6C, sb);
    w(7'h6A, 8'h40);
    for (int i = 0; i < 5; i++) begin
      q.push_back(8'({$random(seed)} % 255));
      w(7'h74, q[i]);
    end
    i_gpr_host.level(n);
    chk(n, 16'h0005);
    drain();
    for (int i = 0; i < DEPTH + 3; i++) begin
      v = 8'({$random(seed)} % 255);
      send(v);
      if (q.size() == DEPTH) void'(q.pop_front());
      q.push_back(v);
    end
    @(negedge core_clk);
    sample_valid = 1'b0;
    repeat (10) @(negedge core_clk);
    chk(16'(ovf), 16'h0003);
    i_gpr_host.level(n);
    chk(n, 16'h0200);
    stop_on_full = 1'b1;
    for (int i = 0; i < 2; i++) begin
      v = 8'({$random(seed)} % 255);
      send(v);
      q.push_back(v);
    end
    @(negedge core_clk);
    sample_valid = 1'b0;
    sample_data = ~sample_data;
    chk(sample_ready, 16'h0000);
    w(7'h74, 8'h5A);
    i_gpr_host.level(n);
    chk(n, 16'h0200);
    drain();
    stop_on_full = 1'b0;
    w(7'h74, 8'h11);
    w(7'h6A, 8'h44);
    rc(7'h6A, 8'h44);
    repeat (8) @(negedge core_clk);
    rc(7'h6A, 8'h40);
    i_gpr_host.level(n);
    chk(n, 16'h0000);
    w(7'h68, 8'hFF);
    w(7'h6A, 8'h41);
    w(7'h74, 8'h55);
    w(7'h6A, 8'h00);
    w(7'h74, 8'h33);
    rc(7'h74, 8'hFF);
    w(7'h6A, 8'h40);
    rc(7'h74, 8'h55);
    w(7'h6A, 8'h50);
    rc(7'h6B, 8'hxx, 1'b1);
    w(7'h6C, 8'h07, 1'b1);
    rc(7'h6C, sb);
    w(7'h6A, 8'h40);
    w(7'h6C, 8'h05);
    w(7'h6B, 8'h80);
    rc(7'h6B, 8'hC0);
    repeat (6) @(negedge core_clk);
    rc(7'h6B, 8'h40);
    rc(7'h6C, 8'h00);
    rc(7'h6A, 8'h00);
    results();
  end
endmodule : gpr_ctrl_top_tb
